//--- logic/isr_status_top.sv
// status reporting core: status summary byte, service request mask,
// request latch, standard event flags and enable, bus request line.
// assumes command decode elsewhere turns commands into one-cycle
// strobes, and that summaries of the other event registers arrive
// as levels already masked by their own enables.

`timescale 1ns/1ps

// Functional notes
// - enabled request pulls bus request line low
// - status byte eight bits, bits 2,1 zero
// - bit 7 operation summary in poll and query
// - latch sets on masked-or rise, poll clears
// - query bit 6 is live masked-or level
// - bit 5 is masked standard event or
// - bit 4 output queue summary both answers
// - bit 3 questionable, bit 0 measurement
// - request mask gates latch, summary, line
// - mask write/read, power-on-clear controls reset
// - mask kept through clear-status
// - event flags cleared by clear or read
// - power flag set; bits 6,1 zero
// - bit 5 syntax, bit 4 run error
// - bit 3 device specific error summary
// - bit 2 query error
// - bit 0 operation complete
// - event enable masks flags into bit 5
// - message available while queue non-empty
module isr_status_top (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic PWR_CLR_I,
	input wire logic OPER_SUM_I,
	input wire logic QUES_SUM_I,
	input wire logic MEAS_SUM_I,
	input wire logic [8:0] OQ_COUNT_I,
	input wire logic CMD_ERR_I,
	input wire logic RUN_ERR_I,
	input wire logic DEV_ERR_I,
	input wire logic QUERY_ERR_I,
	input wire logic OP_DONE_I,
	input wire logic CLS_I,
	input wire logic RMASK_WR_I,
	input wire logic [7:0] RMASK_DATA_I,
	input wire logic ESE_WR_I,
	input wire logic [7:0] ESE_DATA_I,
	input wire logic EVF_RD_I,
	input wire logic SSB_RD_I,
	input wire logic SPOLL_I,
	output logic [7:0] RMASK_VAL_O,
	output logic [7:0] ESE_VAL_O,
	output logic [7:0] EVF_DATA_O,
	output logic [7:0] SSB_DATA_O,
	output logic [7:0] SPOLL_DATA_O,
	output logic SRQ_O,
	output logic SRQ_OE_O
);

	logic [7:0] req_mask_r;
	logic [7:0] ese_r;
	logic [7:0] sef_flags;
	logic [7:0] sef_set;
	logic [7:0] ssb_core;
	logic event_summary;
	logic message_available;
	logic master_summary;
	logic master_summary_q_r;
	logic request_service_latched_r;
	logic request_service_latched_nxt;
	logic [7:0] ssb_data_r;
	logic [7:0] spoll_data_r;

	// ----------------------------------------------------------------
	// standard event flags
	// ----------------------------------------------------------------
	// event positions
	always_comb begin
		sef_set = isr_pkg::BYTE_ZERO;
		sef_set[isr_pkg::SEF_COMMAND_ERROR] = CMD_ERR_I;
		sef_set[isr_pkg::SEF_CANNOT_RUN_ERROR] = RUN_ERR_I;
		sef_set[isr_pkg::SEF_DEVICE_SPECIFIC_ERROR] = DEV_ERR_I;
		sef_set[isr_pkg::SEF_QUERY_ERROR] = QUERY_ERR_I;
		sef_set[isr_pkg::SEF_OPERATION_COMPLETE] = OP_DONE_I;
	end

	isr_event_reg u_sef (
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.set_i(sef_set),
		.clr_i(CLS_I),
		.rd_i(EVF_RD_I),
		.flags_o(sef_flags),
		.rd_data_o(EVF_DATA_O)
	);

	// ----------------------------------------------------------------
	// mask registers
	// ----------------------------------------------------------------
	// masks are nonvolatile unless power-on-clear is selected, so a
	// reset without that setting leaves them untouched on purpose
	// request mask write
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I && PWR_CLR_I) begin
			req_mask_r <= isr_pkg::MASK_CLEAR_VALUE;
		end else if (!SYS_RST_I && RMASK_WR_I) begin
			req_mask_r <= RMASK_DATA_I & isr_pkg::SSB_USED_MASK;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I && PWR_CLR_I) begin
			ese_r <= isr_pkg::MASK_CLEAR_VALUE;
		end else if (!SYS_RST_I && ESE_WR_I) begin
			ese_r <= ESE_DATA_I;
		end
	end

	assign RMASK_VAL_O = req_mask_r;
	assign ESE_VAL_O = ese_r;

	// ----------------------------------------------------------------
	// status byte assembly
	// ----------------------------------------------------------------
	// masked event summary
	assign event_summary = |(sef_flags & ese_r);
	assign message_available = (OQ_COUNT_I != 9'h000);

	always_comb begin
		ssb_core = isr_pkg::BYTE_ZERO;
		ssb_core[isr_pkg::SSB_OPERATION_SUMMARY] = OPER_SUM_I;
		ssb_core[isr_pkg::SSB_EVENT_SUMMARY_BIT] = event_summary;
		ssb_core[isr_pkg::SSB_MESSAGE_AVAILABLE] = message_available;
		ssb_core[isr_pkg::SSB_QUESTIONABLE_SUMMARY] = QUES_SUM_I;
		ssb_core[isr_pkg::SSB_MEASUREMENT_SUMMARY] = MEAS_SUM_I;
	end

	assign master_summary = |(ssb_core & req_mask_r & isr_pkg::SSB_USED_MASK);

	// ----------------------------------------------------------------
	// request latch
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			master_summary_q_r <= 1'b0;
		end else begin
			master_summary_q_r <= master_summary;
		end
	end

	always_comb begin
		request_service_latched_nxt = request_service_latched_r;
		if (SPOLL_I) begin
			request_service_latched_nxt = 1'b0;
		end
		if (master_summary && !master_summary_q_r) begin
			request_service_latched_nxt = 1'b1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			request_service_latched_r <= 1'b0;
		end else begin
			request_service_latched_r <= request_service_latched_nxt;
		end
	end

	// ----------------------------------------------------------------
	// answers
	// ----------------------------------------------------------------
	// poll carries latch
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			spoll_data_r <= isr_pkg::BYTE_ZERO;
		end else if (SPOLL_I) begin
			spoll_data_r <= ssb_core;
			spoll_data_r[isr_pkg::SSB_REQUEST_SERVICE] <= request_service_latched_r;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			ssb_data_r <= isr_pkg::BYTE_ZERO;
		end else if (SSB_RD_I) begin
			ssb_data_r <= ssb_core;
			ssb_data_r[isr_pkg::SSB_REQUEST_SERVICE] <= master_summary;
		end
	end

	assign SPOLL_DATA_O = spoll_data_r;
	assign SSB_DATA_O = ssb_data_r;

	// ----------------------------------------------------------------
	// bus request line
	// ----------------------------------------------------------------
	// wired-or line: only ever pulled low, never driven high
	// pull low while requesting
	assign SRQ_O = 1'b0;
	assign SRQ_OE_O = request_service_latched_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	latch_rise_set_a: assert property (
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(master_summary && !master_summary_q_r) |=> request_service_latched_r)
		else $error("request latch missed a rising summary");

	latch_poll_clr_a: assert property (
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(SPOLL_I && !(master_summary && !master_summary_q_r)) |=> !request_service_latched_r)
		else $error("serial poll did not clear request latch");

	srq_drive_a: assert property (
		@(posedge CLK_I) disable iff (SYS_RST_I)
		$rose(SRQ_OE_O) |-> $past(master_summary) && SRQ_O == 1'b0)
		else $error("request line pulled without an enabled cause");

	byte_zero_bits_a: assert property (
		@(posedge CLK_I) disable iff (SYS_RST_I)
		SSB_DATA_O[2:1] == 2'b00 && SPOLL_DATA_O[2:1] == 2'b00)
		else $error("unused status byte bits not zero");

	query_live_or_a: assert property (
		@(posedge CLK_I) disable iff (SYS_RST_I)
		SSB_RD_I |=> SSB_DATA_O[6] == $past(master_summary))
		else $error("status query bit 6 not live summary");

	poll_byte_a: assert property (
		@(posedge CLK_I) disable iff (SYS_RST_I)
		SPOLL_I |=> SPOLL_DATA_O[7] == $past(OPER_SUM_I)
			&& SPOLL_DATA_O[4] == ($past(OQ_COUNT_I) != 9'h000)
			&& SPOLL_DATA_O[6] == $past(request_service_latched_r))
		else $error("serial poll byte fields wrong");

	flags_read_clr_a: assert property (
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(EVF_RD_I && sef_set == 8'h00) |=> sef_flags == 8'h00
			&& EVF_DATA_O == $past(sef_flags))
		else $error("event flags not returned and cleared");

	flag_set_wins_a: assert property (
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(EVF_RD_I && CMD_ERR_I) |=> sef_flags[5])
		else $error("event lost to same-cycle read clear");

	mask_keep_clr_a: assert property (
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(CLS_I && !RMASK_WR_I) |=> $stable(req_mask_r))
		else $error("clear-status changed request mask");

	event_summary_a: assert property (
		@(posedge CLK_I) disable iff (SYS_RST_I)
		SSB_RD_I |=> SSB_DATA_O[5] == |($past(sef_flags) & $past(ese_r)))
		else $error("event summary bit wrong");

	power_flag_rst_a: assert property (
		@(posedge CLK_I)
		$fell(SYS_RST_I) |-> sef_flags == isr_pkg::SEF_RESET_VALUE)
		else $error("power flag not set after reset");

endmodule

//--- logic/isr_pkg.sv
// package for the instrument status reporting block: bit positions,
// reset values and field widths shared by the design modules.
// assumes a single clock domain and a synchronous, active-high reset.

package isr_pkg;

	// ----------------------------------------------------------------
	// register widths
	// ----------------------------------------------------------------
	localparam int REG_W = 8;

	// ----------------------------------------------------------------
	// status summary byte bit positions
	// ----------------------------------------------------------------
	localparam int SSB_OPERATION_SUMMARY = 7;
	localparam int SSB_REQUEST_SERVICE = 6;
	localparam int SSB_EVENT_SUMMARY_BIT = 5;
	localparam int SSB_MESSAGE_AVAILABLE = 4;
	localparam int SSB_QUESTIONABLE_SUMMARY = 3;
	localparam int SSB_MEASUREMENT_SUMMARY = 0;
	// bits that may take part in a request; 6, 2 and 1 never do
	localparam logic [7:0] SSB_USED_MASK = 8'hb9;

	// ----------------------------------------------------------------
	// standard event flags bit positions
	// ----------------------------------------------------------------
	localparam int SEF_POWER_ON_FLAG = 7;
	localparam int SEF_COMMAND_ERROR = 5;
	localparam int SEF_CANNOT_RUN_ERROR = 4;
	localparam int SEF_DEVICE_SPECIFIC_ERROR = 3;
	localparam int SEF_QUERY_ERROR = 2;
	localparam int SEF_OPERATION_COMPLETE = 0;
	localparam logic [7:0] SEF_USED_MASK = 8'hbd;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] SEF_RESET_VALUE = 8'h80;
	localparam logic [7:0] MASK_CLEAR_VALUE = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int OQ_COUNT_W = 9;

endpackage

//--- logic/isr_event_reg.sv
// sticky event flag register: set pulses, a clear strobe, and a
// read that returns the value and then clears it.
// assumes set inputs are synchronous to the clock.

`timescale 1ns/1ps

module isr_event_reg (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] set_i,
	input wire logic clr_i,
	input wire logic rd_i,
	output logic [7:0] flags_o,
	output logic [7:0] rd_data_o
);

	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	logic [7:0] rd_data_r;

	// ----------------------------------------------------------------
	// flag storage
	// ----------------------------------------------------------------
	// set beats clear
	always_comb begin
		flags_nxt = flags_r;
		if (clr_i || rd_i) begin
			flags_nxt = isr_pkg::BYTE_ZERO;
		end
		flags_nxt = (flags_nxt | set_i) & isr_pkg::SEF_USED_MASK;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_r <= isr_pkg::SEF_RESET_VALUE;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// ----------------------------------------------------------------
	// query answer
	// ----------------------------------------------------------------
	// read returns then clears
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_r <= isr_pkg::BYTE_ZERO;
		end else if (rd_i) begin
			rd_data_r <= flags_r;
		end
	end

	assign flags_o = flags_r;
	assign rd_data_o = rd_data_r;

endmodule

//--- test/isr_ctrl_model.sv
// bus controller model: answers a service request with a serial poll.
// assumes the bench enables it only when a poll is wanted.

`timescale 1ns/1ps

module isr_ctrl_model #(
	parameter int DLY = 2
) (
	input wire logic clk_i,
	input wire logic srq_oe_i,
	input wire logic en_i,
	output logic spoll_o
);
	int cnt;

	initial begin
		spoll_o = 1'b0;
		cnt = 0;
	end

	// ------------------------------------------------------------
	// poll after a settable delay
	// ------------------------------------------------------------
	// poll finds cause
	always @(negedge clk_i) begin
		spoll_o <= 1'b0;
		if (en_i && srq_oe_i && !spoll_o) begin
			cnt <= cnt + 1;
			if (cnt >= DLY) begin
				spoll_o <= 1'b1;
				cnt <= 0;
			end
		end else begin
			cnt <= 0;
		end
	end
endmodule

//--- test/tb_top.sv
// testbench for the status reporting core: strobes driven on the
// falling edge, answers compared one cycle later.
// assumes the controller model issues the serial polls.

`timescale 1ns/1ps

module tb_top;
	logic clk, rst, pwr_clr, oper, ques, meas, poll_en, spoll, srq, srq_oe;
	logic [8:0] oq;
	logic [4:0] ev;
	logic [4:0] strb;
	logic [7:0] rmask_d, ese_d, rmask_v, ese_v, evf_q, ssb_q, spoll_q;
	int n_mismatch, comparisons;

	isr_status_top isr_status_top_inst (.CLK_I(clk), .SYS_RST_I(rst), .PWR_CLR_I(pwr_clr),
		.OPER_SUM_I(oper), .QUES_SUM_I(ques), .MEAS_SUM_I(meas), .OQ_COUNT_I(oq),
		.CMD_ERR_I(ev[0]), .RUN_ERR_I(ev[1]), .DEV_ERR_I(ev[2]), .QUERY_ERR_I(ev[3]),
		.OP_DONE_I(ev[4]), .CLS_I(strb[2]), .RMASK_WR_I(strb[0]), .RMASK_DATA_I(rmask_d),
		.ESE_WR_I(strb[1]), .ESE_DATA_I(ese_d), .EVF_RD_I(strb[3]), .SSB_RD_I(strb[4]),
		.SPOLL_I(spoll), .RMASK_VAL_O(rmask_v), .ESE_VAL_O(ese_v), .EVF_DATA_O(evf_q),
		.SSB_DATA_O(ssb_q), .SPOLL_DATA_O(spoll_q), .SRQ_O(srq), .SRQ_OE_O(srq_oe));

	isr_ctrl_model isr_ctrl_model_inst (.clk_i(clk), .srq_oe_i(srq_oe), .en_i(poll_en),
		.spoll_o(spoll));

	// ------------------------------------------------------------
	// clock, compare and access tasks
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		chk8(nm, {7'h00, e}, {7'h00, g});
	endtask

	task automatic pulse(input int i, input logic [7:0] d);
		@(negedge clk);
		rmask_d = d;
		ese_d = d;
		strb[i] = 1'b1;
		@(negedge clk);
		strb[i] = 1'b0;
	endtask

	task automatic rd(input int i, input logic [7:0] e);
		pulse(i, 8'h00);
		chk8(i == 3 ? "event flags" : "status byte", e, i == 3 ? evf_q : ssb_q);
	endtask

	task automatic poll(input logic [7:0] e);
		poll_en = 1'b1;
		repeat (10) @(negedge clk);
		poll_en = 1'b0;
		chk8("poll byte", e, spoll_q);
		chk1("request line", 1'b0, srq_oe);
	endtask

	task automatic finish_test;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// hang guard, well above the hundred or so cycles the tests take
	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		int pos[5] = '{5, 4, 3, 2, 0};
		{rst, pwr_clr, oper, ques, meas, poll_en, oq, ev, strb} = {2'b11, 4'h0, 9'h000, 10'h000};
		{rmask_d, ese_d, n_mismatch, comparisons} = '0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		chk8("request mask", 8'h00, rmask_v);
		rd(3, 8'h80);
		rd(3, 8'h00);
		for (int i = 0; i < 5; i++) begin
			@(negedge clk) ev[i] = 1'b1;
			@(negedge clk) ev[i] = 1'b0;
			rd(3, 8'h01 << pos[i]);
		end
		// set and read clear in one cycle: the set must win
		@(negedge clk) {ev[0], strb[3]} = 2'b11;
		@(negedge clk) {ev[0], strb[3]} = 2'b00;
		rd(3, 8'h20);
		pulse(0, 8'hff);
		chk8("request mask", 8'hb9, rmask_v);
		pulse(1, 8'h20);
		chk8("event enable", 8'h20, ese_v);
		@(negedge clk) {oper, ques, meas, oq} = {3'b111, 9'h1ff};
		repeat (3) @(negedge clk);
		chk1("request line", 1'b1, srq_oe);
		chk1("line data", 1'b0, srq);
		rd(4, 8'hd9);
		poll(8'hd9);
		@(negedge clk) ev[0] = 1'b1;
		@(negedge clk) ev[0] = 1'b0;
		rd(4, 8'hf9);
		pulse(1, 8'h00);
		rd(4, 8'hd9);
		pulse(0, 8'h00);
		rd(4, 8'h99);
		@(negedge clk) {oper, ques, meas, oq} = '0;
		rd(4, 8'h00);
		pulse(0, 8'h10);
		pulse(2, 8'h00);
		chk8("request mask", 8'h10, rmask_v);
		rd(3, 8'h00);
		@(negedge clk) oq = 9'h001;
		repeat (3) @(negedge clk);
		chk1("request line", 1'b1, srq_oe);
		poll(8'h50);
		// second reset keeps the mask when clearing is off
		@(negedge clk) {oq, pwr_clr, rst} = {9'h000, 2'b01};
		repeat (5) @(negedge clk);
		rst = 1'b0;
		chk8("request mask", 8'h10, rmask_v);
		chk1("request line", 1'b0, srq_oe);
		rd(3, 8'h80);
		finish_test();
	end
endmodule
